// ==== hw/lvds_dc_balance_encoder_defines.svh ====
// constants of the per-lane dc-balance encoder
`ifndef LVDS_DC_BALANCE_ENCODER_DEFINES_SVH
`define LVDS_DC_BALANCE_ENCODER_DEFINES_SVH

// apb register byte addresses
`define ADDR_CTRL 12'h000
`define ADDR_DISP 12'h004
`define ADDR_STRAP 12'h008

// control register fields and reset value
`define CTRL_RESET 32'h0000_0001
`define CTRL_ENABLE_BIT 0
`define CTRL_SEED_LSB 4
`define CTRL_SEED_MSB 7
`define CTRL_RELOAD_BIT 8

// running disparity limits, 4-bit and 5-bit signed
`define RD_MAX4 4'sh7
`define RD_MIN4 4'sha
`define RD_MAX5 5'sh07
`define RD_MIN5 5'sh1a
`define RD_ZERO4 4'sh0
`define DISP_ZERO5 5'sh00
`define DISP_ONE5 5'sh01

// pixel payload per lane and disparity bias of a payload word
`define LANE_BITS 6
`define DISP_BIAS5 5'sh06

// control symbols on data lanes during blanking
`define SYM_CTRL0_POS 7'h70
`define SYM_CTRL0_NEG 7'h78
`define SYM_CTRL1_POS 7'h60
`define SYM_CTRL1_NEG 7'h7c

// clock lane symbols
`define SYM_CLK_ACT_POS 7'h70
`define SYM_CLK_ACT_NEG 7'h78
`define SYM_CLK_BLK_POS 7'h60
`define SYM_CLK_BLK_NEG 7'h7c
`define SYM_CLK_LEGACY 7'h63

// strap settle cycles after reset release
`define STRAP_WAIT 2'h3

`endif

// ==== hw/lvds_dc_balance_pkg.sv ====
// types shared by the dc-balance encoder
package lvds_dc_balance_pkg;

   typedef struct packed {
      logic [47:0] data;
      logic hsync;
      logic vsync;
      logic video;
   } pixel_in_s;

   typedef struct packed {
      logic balance;
      logic edge_fall;
      logic polarity;
      logic dual;
   } strap_s;

   typedef struct packed {
      logic flag;
      logic [6:0] sym;
   } lane_out_s;

   typedef enum logic [1:0] {
      ST_WAIT = 2'b01,
      ST_RUN = 2'b10
   } run_state_e;

endpackage

// ==== hw/lvds_dc_balance_encoder.sv ====
// dc-balance lane encoder of a display serial-link transmitter, with apb control
`include "lvds_dc_balance_encoder_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module lvds_dc_balance_encoder
   import lvds_dc_balance_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [11:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic pix_clk_i,
   input wire logic [47:0] pix_data_i,
   input wire logic hsync_i,
   input wire logic vsync_i,
   input wire logic active_video_flag_i,
   input wire logic balance_select_strap_i,
   input wire logic clock_edge_strap_i,
   input wire logic enable_polarity_strap_i,
   input wire logic pixel_width_strap_i,
   output wire lane_out_s [7:0] lane_o,
   output logic [6:0] link_clock_primary_o,
   output logic [6:0] link_clock_secondary_o,
   output logic word_valid_o
);

   // ones minus zeros of one six-bit payload word
   function automatic logic signed [4:0] word_disp(input logic [5:0] w);
      logic [4:0] ones;
      ones = 5'h00;
      for (int b = 0; b < `LANE_BITS; b++)
      begin
         ones = ones + {4'h0, w[b]};
      end
      word_disp = $signed(ones + ones) - `DISP_BIAS5;
   endfunction

   // two-flop synchronisers for every pin from the host side
   pixel_in_s px_s1, px_s2;
   logic pclk_s1, pclk_s2, pclk_s3;
   strap_s strap_s1, strap_s2;
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         px_s1 <= '0;
         px_s2 <= '0;
         pclk_s1 <= 1'b0;
         pclk_s2 <= 1'b0;
         pclk_s3 <= 1'b0;
         strap_s1 <= '0;
         strap_s2 <= '0;
      end
      else
      begin
         px_s1 <= {pix_data_i, hsync_i, vsync_i, active_video_flag_i};
         px_s2 <= px_s1;
         pclk_s1 <= pix_clk_i;
         pclk_s2 <= pclk_s1;
         pclk_s3 <= pclk_s2; // edge detect history, reads the second stage only
         strap_s1 <= {balance_select_strap_i, clock_edge_strap_i, enable_polarity_strap_i, pixel_width_strap_i};
         strap_s2 <= strap_s1;
      end
   end

   // straps caught once after reset release; later pin changes are ignored
   run_state_e state_reg, state_next;
   strap_s strap_reg, strap_next;
   logic [1:0] wait_reg, wait_next;
   always_comb
   begin
      state_next = state_reg;
      strap_next = strap_reg;
      wait_next = wait_reg;
      unique case (state_reg)
         ST_WAIT:
         begin
            wait_next = wait_reg + 2'h1;
            if (wait_reg == `STRAP_WAIT)
            begin
               strap_next = strap_s2;
               state_next = ST_RUN;
            end
         end
         ST_RUN:
         begin
            state_next = ST_RUN;
         end
         default:
         begin
            state_next = ST_WAIT;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_reg <= ST_WAIT;
         strap_reg <= '0;
         wait_reg <= 2'h0;
      end
      else
      begin
         state_reg <= state_next;
         strap_reg <= strap_next;
         wait_reg <= wait_next;
      end
   end

   // apb slave: one wait state, pready and data both from flops
   logic [31:0] ctrl_reg, ctrl_next;
   logic [31:0] prdata_next;
   logic pready_next, pslverr_next, reload_next, reload_reg;
   logic [31:0] disp_all;
   logic apb_done, addr_ok;
   assign apb_done = psel_i & penable_i & pready_o;
   assign addr_ok = (paddr_i == `ADDR_CTRL) | (paddr_i == `ADDR_DISP) | (paddr_i == `ADDR_STRAP);
   always_comb
   begin
      ctrl_next = ctrl_reg;
      reload_next = 1'b0;
      pready_next = psel_i & penable_i & ~pready_o;
      pslverr_next = psel_i & penable_i & ~pready_o & ~addr_ok;
      prdata_next = 32'h0000_0000;
      if (psel_i & penable_i & ~pready_o & ~pwrite_i)
      begin
         unique case (1'b1)
            paddr_i == `ADDR_CTRL: prdata_next = ctrl_reg;
            paddr_i == `ADDR_DISP: prdata_next = disp_all;
            paddr_i == `ADDR_STRAP: prdata_next = {27'h0, state_reg == ST_RUN, strap_reg};
            default: prdata_next = 32'h0000_0000;
         endcase
      end
      // writes take effect only at the completing edge
      if (apb_done & pwrite_i & (paddr_i == `ADDR_CTRL))
      begin
         ctrl_next = {24'h0, pwdata_i[`CTRL_SEED_MSB:`CTRL_SEED_LSB], 3'h0, pwdata_i[`CTRL_ENABLE_BIT]};
         reload_next = pwdata_i[`CTRL_RELOAD_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ctrl_reg <= `CTRL_RESET;
         reload_reg <= 1'b0;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         reload_reg <= reload_next;
         pready_o <= pready_next;
         pslverr_o <= pslverr_next;
         prdata_o <= prdata_next;
      end
   end

   // seed for a reload, pulled into the legal disparity range
   logic signed [3:0] seed;
   assign seed = ($signed(ctrl_reg[`CTRL_SEED_MSB:`CTRL_SEED_LSB]) < `RD_MIN4) ? `RD_MIN4
                 : $signed(ctrl_reg[`CTRL_SEED_MSB:`CTRL_SEED_LSB]);

   // primary pixel clock edge and the encode strobe
   logic rise, fall, sample_pulse, encode_go, video_on;
   assign rise = pclk_s2 & ~pclk_s3;
   assign fall = ~pclk_s2 & pclk_s3;
   assign sample_pulse = strap_reg.edge_fall ? fall : rise;
   assign encode_go = sample_pulse & (state_reg == ST_RUN) & ctrl_reg[`CTRL_ENABLE_BIT];
   assign video_on = (px_s2.video == strap_reg.polarity);

   // per-lane encoder; lanes 4..7 carry the second pixel in dual mode
   generate
      for (genvar i = 0; i < 8; i++)
      begin : g_lane
         lane_out_s word_reg, word_next;
         logic signed [3:0] rd_reg, rd_next;
         logic signed [4:0] d, mod, sum;
         logic [5:0] payload;
         logic ctrl_bit, inv, lane_on;
         assign payload = px_s2.data[i * `LANE_BITS +: `LANE_BITS];
         assign ctrl_bit = ((i % 4) == 0) ? px_s2.hsync : ((i % 4) == 1) ? px_s2.vsync
                           : ((i % 4) == 2) ? px_s2.video : 1'b0;
         assign lane_on = (i < 4) | strap_reg.dual;
         always_comb
         begin
            word_next = word_reg;
            rd_next = rd_reg;
            d = word_disp(payload);
            // zero running disparity always inverts
            if (rd_reg == `RD_ZERO4)
               inv = 1'b1;
            else if (rd_reg > `RD_ZERO4)
               inv = (d > `DISP_ZERO5);
            else
               inv = ~(d > `DISP_ZERO5);
            mod = inv ? (`DISP_ONE5 - d) : (d - `DISP_ONE5);
            sum = {rd_reg[3], rd_reg} + mod;
            if (encode_go)
            begin
               if (!lane_on)
                  word_next = '0;
               else if (!strap_reg.balance)
                  word_next = '{flag: 1'b0, sym: {ctrl_bit, payload}};
               else if (video_on)
               begin
                  word_next = '{flag: inv, sym: {inv, payload ^ {`LANE_BITS{inv}}}};
                  // clamp keeps the register inside -6..+7
                  if (sum > `RD_MAX5)
                     rd_next = `RD_MAX4;
                  else if (sum < `RD_MIN5)
                     rd_next = `RD_MIN4;
                  else
                     rd_next = sum[3:0];
               end
               else if (ctrl_bit)
                  word_next = '{flag: 1'b0, sym: (rd_reg > `RD_ZERO4) ? `SYM_CTRL1_POS : `SYM_CTRL1_NEG};
               else
                  word_next = '{flag: 1'b0, sym: (rd_reg > `RD_ZERO4) ? `SYM_CTRL0_POS : `SYM_CTRL0_NEG};
            end
            // a reload overrides an update in the same cycle
            if (reload_reg)
               rd_next = seed;
         end
         always_ff @(posedge clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               word_reg <= '0;
               rd_reg <= `RD_ZERO4;
            end
            else
            begin
               word_reg <= word_next;
               rd_reg <= rd_next;
            end
         end
         assign lane_o[i] = word_reg;
         assign disp_all[i * 4 +: 4] = rd_reg;
      end
   endgenerate

   // clock lanes carry the video state, steered by lane 0 disparity
   logic [6:0] clk_next, link_clock_secondary_next;
   logic signed [3:0] rd0;
   logic valid_next;
   assign rd0 = $signed(disp_all[3:0]);
   always_comb
   begin
      clk_next = link_clock_primary_o;
      link_clock_secondary_next = link_clock_secondary_o;
      valid_next = encode_go;
      if (encode_go)
      begin
         if (!strap_reg.balance)
            clk_next = `SYM_CLK_LEGACY;
         else if (video_on)
            clk_next = (rd0 > `RD_ZERO4) ? `SYM_CLK_ACT_POS : `SYM_CLK_ACT_NEG;
         else
            clk_next = (rd0 > `RD_ZERO4) ? `SYM_CLK_BLK_POS : `SYM_CLK_BLK_NEG;
         // single mode leaves the secondary clock quiet to save power
         link_clock_secondary_next = strap_reg.dual ? clk_next : 7'h00;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         link_clock_primary_o <= 7'h00;
         link_clock_secondary_o <= 7'h00;
         word_valid_o <= 1'b0;
      end
      else
      begin
         link_clock_primary_o <= clk_next;
         link_clock_secondary_o <= link_clock_secondary_next;
         word_valid_o <= valid_next;
      end
   end

   // checks on lane 0 and the clock lanes
   logic signed [4:0] d0;
   logic bal_act, bal_blk;
   assign d0 = word_disp(px_s2.data[5:0]);
   assign bal_act = encode_go & strap_reg.balance & video_on;
   assign bal_blk = encode_go & strap_reg.balance & ~video_on;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_rd_range;
      (rd0 <= `RD_MAX4) && (rd0 >= `RD_MIN4);
   endproperty
   a_rd_range: assert property (p_rd_range) else $error("running disparity out of range");

   property p_zero_inverts;
      bal_act && (rd0 == `RD_ZERO4) |=> lane_o[0].flag && (lane_o[0].sym[5:0] == ~$past(px_s2.data[5:0]));
   endproperty
   a_zero_inverts: assert property (p_zero_inverts) else $error("zero disparity word not inverted");

   property p_pos_pos;
      bal_act && (rd0 > `RD_ZERO4) && (d0 > `DISP_ZERO5) |=> lane_o[0].flag;
   endproperty
   a_pos_pos: assert property (p_pos_pos) else $error("positive on positive not inverted");

   property p_neg_pos;
      bal_act && (rd0 < `RD_ZERO4) && (d0 > `DISP_ZERO5) |=> !lane_o[0].flag;
   endproperty
   a_neg_pos: assert property (p_neg_pos) else $error("negative on positive inverted");

   property p_neg_neg;
      bal_act && (rd0 < `RD_ZERO4) && (d0 <= `DISP_ZERO5) |=> lane_o[0].flag;
   endproperty
   a_neg_neg: assert property (p_neg_neg) else $error("negative on non-positive not inverted");

   property p_pos_neg;
      bal_act && (rd0 > `RD_ZERO4) && (d0 <= `DISP_ZERO5) |=> !lane_o[0].flag;
   endproperty
   a_pos_neg: assert property (p_pos_neg) else $error("positive on non-positive inverted");

   property p_flag_mirror;
      bal_act |=> lane_o[0].flag == lane_o[0].sym[6];
   endproperty
   a_flag_mirror: assert property (p_flag_mirror) else $error("flag bit not in data word");

   property p_rd_step;
      bal_act && !reload_reg && (rd0 == `RD_ZERO4) && (d0 == `DISP_ZERO5) |=> rd0 == 4'sh1;
   endproperty
   a_rd_step: assert property (p_rd_step) else $error("running disparity step wrong");

   property p_blank_hsync0_pos;
      bal_blk && !px_s2.hsync && (rd0 > `RD_ZERO4) |=> (lane_o[0].sym == `SYM_CTRL0_POS) && !lane_o[0].flag;
   endproperty
   a_blank_hsync0_pos: assert property (p_blank_hsync0_pos) else $error("blank word wrong");

   property p_blank_hsync1_neg;
      bal_blk && px_s2.hsync && (rd0 <= `RD_ZERO4) |=> (lane_o[0].sym == `SYM_CTRL1_NEG) && !lane_o[0].flag;
   endproperty
   a_blank_hsync1_neg: assert property (p_blank_hsync1_neg) else $error("blank word wrong");

   property p_blank_holds_rd;
      bal_blk && !reload_reg |=> $stable(rd0);
   endproperty
   a_blank_holds_rd: assert property (p_blank_holds_rd) else $error("blanking changed disparity");

   property p_dual_clock;
      word_valid_o && strap_reg.dual |-> link_clock_secondary_o == link_clock_primary_o;
   endproperty
   a_dual_clock: assert property (p_dual_clock) else $error("secondary clock differs");

   property p_legacy;
      encode_go && !strap_reg.balance |=> !lane_o[0].flag && (link_clock_primary_o == `SYM_CLK_LEGACY)
         && (lane_o[0].sym == {$past(px_s2.hsync), $past(px_s2.data[5:0])});
   endproperty
   a_legacy: assert property (p_legacy) else $error("legacy word wrong");

   c_active_inverted: cover property (bal_act ##1 lane_o[0].flag);
   c_blanking: cover property (bal_blk ##1 word_valid_o);
   c_legacy: cover property (encode_go && !strap_reg.balance);
   c_rd_saturate: cover property (rd0 == `RD_MAX4);

endmodule // lvds_dc_balance_encoder

`default_nettype wire

// ==== verif/lvds_link_receiver_model.sv ====
// remote display receiver model: recovers payload and video state from lane words
`timescale 1ns/100ps
`default_nettype none

module lvds_link_receiver_model
   import lvds_dc_balance_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire lane_out_s [7:0] lane_i,
   input wire logic [6:0] link_clock_primary_i,
   input wire logic word_valid_i,
   output logic [7:0][5:0] rx_payload_o,
   output logic rx_active_o
);
   logic [7:0][5:0] payload_next;
   logic active_next;

   // undo the inversion named by the flag; the clock word tells pixel from control
   always_comb
   begin
      payload_next = rx_payload_o;
      active_next = rx_active_o;
      if (word_valid_i)
      begin
         for (int i = 0; i < 8; i++)
         begin
            payload_next[i] = lane_i[i].sym[5:0] ^ {6{lane_i[i].flag}};
         end
         active_next = (link_clock_primary_i == 7'h70) || (link_clock_primary_i == 7'h78);
      end
   end

   // only framed words are taken, as a deserializer would
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rx_payload_o <= '0;
         rx_active_o <= 1'b0;
      end
      else
      begin
         rx_payload_o <= payload_next;
         rx_active_o <= active_next;
      end
   end
endmodule // lvds_link_receiver_model
`default_nettype wire

// ==== verif/lvds_dc_balance_encoder_bench.sv ====
// self-checking bench of the dc-balance lane encoder
`timescale 1ns/100ps
`default_nettype none

module lvds_dc_balance_encoder_bench
   import lvds_dc_balance_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic pix_clk = 1'b0;
   logic [47:0] pix_data = 48'h0;
   logic hsync = 1'b0;
   logic vsync = 1'b0;
   logic video = 1'b0;
   logic balance_select_strap = 1'b1;
   logic ef = 1'b0;
   logic pol = 1'b1;
   logic dual = 1'b1;
   wire [31:0] prdata;
   wire pready;
   wire pslverr;
   wire lane_out_s [7:0] lane;
   wire [6:0] link_clock_primary;
   wire [6:0] link_clock_secondary;
   wire wv;
   wire [7:0][5:0] rx_pay;
   wire rx_act;
   int rdisp [8];
   int tests_run = 0;
   int n_mismatch = 0;
   int cyc = 0;

   lvds_dc_balance_encoder i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .paddr_i(paddr), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .pix_clk_i(pix_clk), .pix_data_i(pix_data), .hsync_i(hsync), .vsync_i(vsync),
      .active_video_flag_i(video), .balance_select_strap_i(balance_select_strap), .clock_edge_strap_i(ef),
      .enable_polarity_strap_i(pol), .pixel_width_strap_i(dual), .lane_o(lane),
      .link_clock_primary_o(link_clock_primary), .link_clock_secondary_o(link_clock_secondary), .word_valid_o(wv));

   lvds_link_receiver_model i_rx (.clk_i(clk_i), .rst_n_i(rst_n_i), .lane_i(lane),
      .link_clock_primary_i(link_clock_primary), .word_valid_i(wv), .rx_payload_o(rx_pay), .rx_active_o(rx_act));

   // 200 mhz system clock
   always #2.5 clk_i = ~clk_i;

   // pixel clock, 80 ns, phase unrelated to the system clock
   initial
   begin
      #3.3;
      forever #40 pix_clk = ~pix_clk;
   end

   // a hang ends the run through the same report
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         $display("mismatch timeout expected end seen hang");
         final_report();
      end
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] q,
      output logic e);
      int n;
      n = 0;
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_i);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("apb_ready", 1, pready);
   endtask

   // reference encoder of one lane word; disparity over the six payload bits
   function automatic void enc(input logic [5:0] p, inout int r, output logic inv);
      int d;
      d = 2 * $countones(p) - 6;
      inv = (r == 0) || (r > 0 && d > 0) || (r < 0 && d <= 0);
      r = r + (inv ? 1 - d : d - 1);
      r = r > 7 ? 7 : (r < -6 ? -6 : r);
   endfunction

   task automatic do_reset(input logic b, input logic f, input logic p, input logic du);
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      balance_select_strap <= b;
      ef <= f;
      pol <= p;
      dual <= du;
      video <= ~p;
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      foreach (rdisp[i]) rdisp[i] = 0;
   endtask

   // data changes on the other pin edge, so it is stable around the primary one
   task automatic send(input logic [47:0] d, input logic hs, input logic vs, input logic act);
      int n;
      logic inv;
      logic [5:0] p;
      logic [6:0] c;
      int r0;
      if (ef)
         @(posedge pix_clk);
      else
         @(negedge pix_clk);
      @(posedge clk_i);
      pix_data <= d;
      hsync <= hs;
      vsync <= vs;
      video <= pol ? act : ~act;
      if (ef)
         @(negedge pix_clk);
      else
         @(posedge pix_clk);
      n = 0;
      do
      begin
         @(negedge clk_i);
         n++;
      end
      while (wv !== 1'b1 && n < 12);
      chk("edge_to_word", 1, (n >= 2 && n <= 6));
      // clock lane word follows lane 0 disparity as it stood before this word
      r0 = rdisp[0];
      for (int i = 0; i < 8; i++)
      begin
         p = d[6*i +: 6];
         if (i > 3 && !dual)
            chk("lane_off", 0, lane[i]);
         else if (!balance_select_strap)
            chk("lane_legacy", {1'b0, p}, {lane[i].flag, lane[i].sym[5:0]});
         else if (act)
         begin
            enc(p, rdisp[i], inv);
            chk("lane_data", {inv, inv, p ^ {6{inv}}}, lane[i]);
         end
         else if (i < 2)
         begin
            c = rdisp[i] > 0 ? ((i ? vs : hs) ? 7'h60 : 7'h70) : ((i ? vs : hs) ? 7'h7c : 7'h78);
            chk("lane_ctrl", {1'b0, c}, lane[i]);
         end
         else
            chk("lane_flag", 0, lane[i].flag);
      end
      if (!balance_select_strap)
         c = 7'h63;
      else if (act)
         c = r0 > 0 ? 7'h70 : 7'h78;
      else
         c = r0 > 0 ? 7'h60 : 7'h7c;
      chk("clock_primary", c, link_clock_primary);
      chk("clock_secondary", dual ? c : 7'h00, link_clock_secondary);
      @(negedge clk_i);
      if (act || !balance_select_strap)
         chk("rx_payload", d[23:0], rx_pay[3:0]);
      chk("rx_active", balance_select_strap && act, rx_act);
   endtask

   task automatic t_regs();
      logic [31:0] q;
      logic e;
      apb(0, 12'h000, 0, q, e);
      chk("ctrl_reset", 32'h0000_0001, q);
      apb(1, 12'h004, 32'hffff_ffff, q, e);
      apb(0, 12'h004, 0, q, e);
      chk("disp_reset", 32'h0000_0000, q);
      apb(0, 12'h008, 0, q, e);
      chk("strap_latch", {balance_select_strap, ef, pol, dual}, q[3:0]);
      apb(0, 12'h00c, 0, q, e);
      chk("unmapped_err", 1, e);
      chk("unmapped_data", 0, q);
      $display("test regs done");
   endtask

   task automatic t_words();
      logic [23:0] w [8];
      w = '{24'h000000, 24'h000000, 24'hffffff, 24'hffffff, 24'h0f0f0f, 24'h3c0fc3, 24'h000fff, 24'hfff000};
      foreach (w[k])
         send({~w[k], w[k]}, 1'b0, 1'b0, 1'b1);
      $display("test words done");
   endtask

   // every sync combination, then the tracked disparities read back
   task automatic t_blank();
      logic [31:0] q;
      logic [31:0] x;
      logic e;
      for (int k = 0; k < 4; k++)
         send(48'h0, k[0], k[1], 1'b0);
      foreach (rdisp[i]) x[4*i +: 4] = rdisp[i][3:0];
      apb(0, 12'h004, 0, q, e);
      chk("disp_track", dual ? x : x & 32'h0000_ffff, dual ? q : q & 32'h0000_ffff);
      $display("test blank done");
   endtask

   task automatic t_seed(input logic [3:0] s, input int v);
      logic [31:0] q;
      logic e;
      apb(1, 12'h000, {23'h0, 1'b1, s, 4'h1}, q, e);
      apb(0, 12'h000, 0, q, e);
      chk("ctrl_seed", {24'h0, s, 4'h1}, q);
      apb(0, 12'h004, 0, q, e);
      chk("disp_seed", {8{v[3:0]}}, q);
      foreach (rdisp[i]) rdisp[i] = v;
      $display("test seed done");
   endtask

   // disabled encoder must stay silent on the link
   task automatic t_off();
      logic [31:0] q;
      logic e;
      int n;
      n = 0;
      apb(1, 12'h000, 32'h0, q, e);
      repeat (64)
      begin
         @(negedge clk_i);
         n += (wv === 1'b1);
      end
      chk("idle_words", 0, n);
      apb(1, 12'h000, 32'h1, q, e);
      $display("test off done");
   endtask

   initial
   begin
      do_reset(1, 0, 1, 1);
      t_regs();
      t_words();
      t_blank();
      t_seed(4'h7, 7);
      t_blank();
      t_words();
      t_blank();
      t_seed(4'h8, -6);
      t_blank();
      t_words();
      t_blank();
      t_off();
      do_reset(1, 1, 0, 0);
      t_regs();
      t_words();
      t_blank();
      do_reset(0, 0, 1, 1);
      t_regs();
      t_words();
      t_blank();
      final_report();
   end
endmodule // lvds_dc_balance_encoder_bench
`default_nettype wire
